// ---- logic/input_overvoltage_fault_handler.sv ----
// Input overvoltage detection and programmable fault response
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Flag a fault whenever measured input voltage exceeds the programmed limit.
// - Limit is an eleven-bit writable mantissa times two to the shared exponent.
// - Limit bits 15:11 are read-only and return the external exponent.
// - Action bits 7:6 choose the response; code zero ignores the fault.
// - Code one rides through delay one, then restarts if fault persists.
// - Code two shuts down at once, disables output, then restarts.
// - Code three holds output off until the fault clears, then re-enables.
// - Delay field picks ride-through 10..1280 ms and restart 252..2604 ms.
// - Retry field gives zero to six attempts or unlimited; exhausted latches off.
// - Delay one times fault to disable; delay two spaces restart attempts.
module input_overvoltage_fault_handler
	import ov_fault_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [4:0] input_voltage_exponent,
	input wire logic input_voltage_valid,
	input wire logic [15:0] input_voltage,
	output logic overvoltage_fault,
	output logic output_enable,
	output logic fault_latched
);
	typedef struct packed {
		fault_state_t state;
		logic [10:0] limit;
		logic [7:0] action;
		logic [15:0] rdata;
		logic fault;
		logic out_en;
		logic [MS_W-1:0] elapsed;
		logic [2:0] retries;
		logic latched;
	} handler_t;

	handler_t s_q;
	handler_t s_d;
	logic phase_start;
	logic ms_tick;

	// ----------------------------------------
	// Linear-format scaling
	// ----------------------------------------
	function automatic logic [FIXED_W-1:0] scale(input logic [10:0] mant, input logic [4:0] expo);
		logic [5:0] shift;
		shift = 6'(signed'({expo[4], expo}) + 6'(EXP_BIAS));
		return {31'h0, mant} << shift;
	endfunction

	tick_prescaler #(
		.CYCLES(TICK_CYCLES_P)
	) u_tick (
		.clock(clock),
		.rst(rst),
		.restart(phase_start),
		.tick(ms_tick)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [1:0] resp;
		logic [2:0] retry_set;
		logic [2:0] dsel;
		logic exhausted;
		resp = s_q.action[RESP_MSB:RESP_LSB];
		retry_set = s_q.action[RETRY_MSB:RETRY_LSB];
		dsel = s_q.action[DELAY_MSB:0];
		exhausted = (retry_set != RETRY_INFINITE) && (s_q.retries >= retry_set);
		s_d = s_q;
		phase_start = 1'b0;

		if (reg_write) begin
			if (reg_addr == LIMIT_OFFSET) begin
				s_d.limit = reg_wdata[MANT_MSB:0];
			end else if (reg_addr == ACTION_OFFSET) begin
				s_d.action = reg_wdata[7:0];
			end
		end
		if (reg_read) begin
			if (reg_addr == LIMIT_OFFSET) begin
				s_d.rdata = {input_voltage_exponent, s_q.limit};
			end else if (reg_addr == ACTION_OFFSET) begin
				s_d.rdata = {8'h00, s_q.action};
			end else begin
				s_d.rdata = 16'h0000;
			end
		end

		if (input_voltage_valid) begin
			s_d.fault = scale(input_voltage[MANT_MSB:0], input_voltage[EXP_MSB:EXP_LSB]) >
				scale(s_q.limit, input_voltage_exponent);
		end

		if (ms_tick && s_q.elapsed != {MS_W{1'b1}}) begin
			s_d.elapsed = s_q.elapsed + 12'h001;
		end

		unique case (s_q.state)
			RUNNING: begin
				s_d.out_en = 1'b1;
				if (s_q.fault && resp == RESP_RIDE) begin
					s_d.state = RIDING;
					phase_start = 1'b1;
				end else if (s_q.fault && resp == RESP_SHUTDOWN) begin
					s_d.out_en = 1'b0;
					s_d.state = exhausted ? LATCHED : RESTART_WAIT;
					phase_start = 1'b1;
				end else if (s_q.fault && resp == RESP_HOLD) begin
					s_d.out_en = 1'b0;
					s_d.state = HOLDING;
				end else if (s_q.fault || s_q.retries == 3'h0) begin
					phase_start = 1'b1;
				end else if (s_q.elapsed >= RESTART_MS[dsel]) begin
					// A clean run of one restart interval forgives earlier attempts
					s_d.retries = 3'h0;
				end
			end
			RIDING: begin
				if (!s_q.fault) begin
					s_d.state = RUNNING;
					phase_start = 1'b1;
				end else if (s_q.elapsed >= RIDE_MS[dsel]) begin
					s_d.out_en = 1'b0;
					s_d.state = exhausted ? LATCHED : RESTART_WAIT;
					phase_start = 1'b1;
				end
			end
			RESTART_WAIT: begin
				if (s_q.elapsed >= RESTART_MS[dsel]) begin
					s_d.out_en = 1'b1;
					if (s_q.retries != RETRY_INFINITE) begin
						s_d.retries = s_q.retries + 3'h1;
					end
					s_d.state = RUNNING;
					phase_start = 1'b1;
				end
			end
			HOLDING: begin
				if (!s_q.fault) begin
					s_d.out_en = 1'b1;
					s_d.state = RUNNING;
					phase_start = 1'b1;
				end
			end
			LATCHED: begin
				s_d.out_en = 1'b0;
			end
			default: begin
				// Unused state codes fall back to normal running
				s_d.state = RUNNING;
				phase_start = 1'b1;
			end
		endcase

		// Latched indication is registered so the pin comes from a flop
		s_d.latched = (s_d.state == LATCHED);

		if (phase_start) begin
			s_d.elapsed = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '{state: RUNNING, limit: LIMIT_RESET, action: ACTION_RESET,
				rdata: 16'h0000, fault: 1'b0, out_en: 1'b1, elapsed: '0, retries: 3'h0,
				latched: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign overvoltage_fault = s_q.fault;
	assign output_enable = s_q.out_en;
	assign fault_latched = s_q.latched;
endmodule
`default_nettype wire

// ---- pkg/ov_fault_pkg.sv ----
// Constants for the input overvoltage fault handler
package ov_fault_pkg;
	// ----------------------------------------
	// Register offsets and fields
	// ----------------------------------------
	localparam logic [7:0] LIMIT_OFFSET = 8'h55;
	localparam logic [7:0] ACTION_OFFSET = 8'h56;
	localparam int EXP_MSB = 15;
	localparam int EXP_LSB = 11;
	localparam int MANT_MSB = 10;
	localparam int RESP_MSB = 7;
	localparam int RESP_LSB = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int DELAY_MSB = 2;
	localparam logic [10:0] LIMIT_RESET = 11'h7ff;
	localparam logic [7:0] ACTION_RESET = 8'h00;
	localparam logic [2:0] RETRY_INFINITE = 3'h7;
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_RIDE = 2'h1;
	localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
	localparam logic [1:0] RESP_HOLD = 2'h3;
	// Linear exponent is signed; bias makes every shift non-negative
	localparam int EXP_BIAS = 16;
	localparam int FIXED_W = 11 + 31;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_MHZ = 250;
	localparam int TICK_PERIOD_US = 1000;
	localparam int TICK_CYCLES = TICK_PERIOD_US * CLOCK_MHZ;
	localparam int MS_W = 12;
	localparam logic [11:0] RIDE_MS [8] = '{12'h00a, 12'h014, 12'h028, 12'h050,
		12'h0a0, 12'h140, 12'h280, 12'h500};
	localparam logic [11:0] RESTART_MS [8] = '{12'h0fc, 12'h22e, 12'h39c, 12'h4ec,
		12'h63c, 12'h78c, 12'h8dc, 12'ha2c};

	typedef enum logic [2:0] {
		RUNNING,
		RIDING,
		RESTART_WAIT,
		HOLDING,
		LATCHED
	} fault_state_t;
endpackage

// ---- logic/tick_prescaler.sv ----
// Millisecond tick generator with phase restart
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
	import ov_fault_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic restart,
	output logic tick
);
	typedef struct packed {
		logic [17:0] count;
		logic tick;
	} presc_t;

	localparam logic [17:0] LAST = 18'(CYCLES - 1);

	presc_t s_q;
	presc_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (restart) begin
			s_d.count = 18'h0;
		end else if (s_q.count == LAST) begin
			s_d.count = 18'h0;
			s_d.tick = 1'b1;
		end else begin
			s_d.count = s_q.count + 18'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule
`default_nettype wire

// ---- test/ov_checker_asserts.sv ----
// Port-level assertions for the overvoltage fault handler
`timescale 1ns/1ps
`default_nettype none
module ov_checker
	import ov_fault_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [4:0] input_voltage_exponent,
	input wire logic input_voltage_valid,
	input wire logic [15:0] input_voltage,
	input wire logic overvoltage_fault,
	input wire logic output_enable,
	input wire logic fault_latched
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence rd_lim;
		reg_read && reg_addr == LIMIT_OFFSET;
	endsequence
	sequence rd_none;
		reg_read && reg_addr != LIMIT_OFFSET && reg_addr != ACTION_OFFSET;
	endsequence
	rst_vals_a: assert property (disable iff (1'b0) rst |=> reg_rdata == 16'h0000
		&& !overvoltage_fault && output_enable && !fault_latched) else $error("bad reset");
	exp_read_a: assert property (rd_lim |=> reg_rdata[15:11] == $past(input_voltage_exponent))
		else $error("exponent field wrong");
	unmapped_read_a: assert property (rd_none |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
	fault_hold_a: assert property (!input_voltage_valid |=> $stable(overvoltage_fault))
		else $error("fault moved without sample");
	zero_sample_a: assert property (input_voltage_valid && input_voltage[10:0] == 11'h000
		|=> !overvoltage_fault) else $error("zero sample flagged");
	latch_off_a: assert property (fault_latched |-> !output_enable) else $error("latched but on");
	latch_keep_a: assert property (fault_latched |=> fault_latched) else $error("latch lost");
	off_cause_a: assert property ($fell(output_enable) |-> overvoltage_fault)
		else $error("off without fault");
endmodule
bind input_overvoltage_fault_handler ov_checker chk_i (
	.clock(clock),
	.rst(rst),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.input_voltage_exponent(input_voltage_exponent),
	.input_voltage_valid(input_voltage_valid),
	.input_voltage(input_voltage),
	.overvoltage_fault(overvoltage_fault),
	.output_enable(output_enable),
	.fault_latched(fault_latched)
);
`default_nettype wire

// ---- test/host_model.sv ----
// Host model that reaches the fault handler registers
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clock,
	output logic reg_write = 1'b0,
	output logic reg_read = 1'b0,
	output logic [7:0] reg_addr = 8'h00,
	output logic [15:0] reg_wdata = 16'h0000,
	input wire logic [15:0] reg_rdata
);
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q);
		@(negedge clock);
		reg_write = w;
		reg_read = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_wdata = ~d;
		@(negedge clock);
		q = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the overvoltage fault handler
`timescale 1ns/1ps
`default_nettype none
module tb
	import ov_fault_pkg::*;
;
	localparam int T = 10;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic reg_write, reg_read, input_voltage_valid = 1'b0;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, q, lim, input_voltage = 16'h0000;
	logic [4:0] input_voltage_exponent = 5'h00;
	logic overvoltage_fault, output_enable, fault_latched;
	int failures = 0;
	int samples_checked = 0;
	// Register model kept from the rules
	int lim_m = 0;
	int act_m = 0;
	longint vs, ls;
	int d2 [8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};
	always #2 clock = ~clock;
	input_overvoltage_fault_handler #(
		.TICK_CYCLES_P(T)
	) input_overvoltage_fault_handler_i (
		.clock(clock),
		.rst(rst),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.input_voltage_exponent(input_voltage_exponent),
		.input_voltage_valid(input_voltage_valid),
		.input_voltage(input_voltage),
		.overvoltage_fault(overvoltage_fault),
		.output_enable(output_enable),
		.fault_latched(fault_latched)
	);
	host_model host_i (
		.clock(clock),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata)
	);
	// Expected read word from the register model
	function automatic logic [15:0] model_rd(input logic [7:0] a);
		if (a == LIMIT_OFFSET)
			return {input_voltage_exponent, 11'(lim_m)};
		else if (a == ACTION_OFFSET)
			return 16'(act_m);
		return 16'h0000;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host_i.acc(1'b1, a, d, q);
		if (a == LIMIT_OFFSET)
			lim_m = int'(d[MANT_MSB:0]);
		else if (a == ACTION_OFFSET)
			act_m = int'(d[7:0]);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic near(input int got, input int exp);
		samples_checked++;
		if (got < exp - 5 || got > exp + 5) begin
			failures++;
			$display("Error %0t: took %0d cycles, expected %0d", $time, got, exp);
		end
	endtask
	task automatic reset_dut;
		rst = 1'b1;
		lim_m = int'(LIMIT_RESET);
		act_m = int'(ACTION_RESET);
		repeat (5) @(negedge clock);
		rst = 1'b0;
	endtask
	task automatic span(input int w, output int n);
		n = 0;
		while (n < 27000 && !(w == 0 ? output_enable === 1'b0 :
			w == 1 ? output_enable === 1'b1 : fault_latched === 1'b1)) begin
			@(negedge clock);
			n++;
		end
	endtask
	task automatic resp(input int c, input int s);
		int n;
		reset_dut();
		wr(ACTION_OFFSET, 16'(c * 64 + 8 + s));
		input_voltage = 16'h0fff;
		input_voltage_valid = 1'b1;
		span(0, n);
		near(n, c == 0 ? 27000 : c == 1 ? (10 << s) * T : 1);
		if (c == 2) begin
			span(2, n);
			near(n, d2[s] * T);
		end
		if (c == 3) begin
			input_voltage = 16'h0000;
			span(1, n);
			near(n, 1);
		end
		input_voltage_valid = 1'b0;
	endtask
	task automatic finish_test;
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		q = 16'($urandom(32'h4e065eda));
		reset_dut();
		host_i.acc(1'b0, LIMIT_OFFSET, 16'h0000, q);
		chk(q, model_rd(LIMIT_OFFSET));
		wr(8'h57, 16'hffff);
		host_i.acc(1'b0, 8'h57, 16'h0000, q);
		chk(q, model_rd(8'h57));
		wr(ACTION_OFFSET, 16'hffff);
		host_i.acc(1'b0, ACTION_OFFSET, 16'h0000, q);
		chk(q, model_rd(ACTION_OFFSET));
		lim = 16'($urandom);
		wr(LIMIT_OFFSET, lim);
		repeat (20) begin
			input_voltage_exponent = 5'($urandom);
			input_voltage = 16'($urandom);
			host_i.acc(1'b0, LIMIT_OFFSET, 16'h0000, q);
			chk(q, model_rd(LIMIT_OFFSET));
			input_voltage_valid = 1'b1;
			@(negedge clock);
			input_voltage_valid = 1'b0;
			@(negedge clock);
			vs = longint'(input_voltage[10:0]) << ($signed(input_voltage[15:11]) + 16);
			ls = longint'(lim_m) << ($signed(input_voltage_exponent) + 16);
			chk(16'(overvoltage_fault), 16'(vs > ls));
		end
		input_voltage_exponent = 5'h00;
		for (int c = 0; c < 4; c++)
			resp(c, int'($urandom % 8));
		finish_test();
	end
	initial begin
		#400000;
		failures++;
		finish_test();
	end
endmodule
`default_nettype wire
